// ---- hw/nps_pkg.sv ----
// Constants and types for the network adapter power-state block
// Contract
// - D0 gives full transmit, receive, interrupts
// - Low states refuse host transmit requests
// - Low states move no received data
// - Low states raise no host interrupt
// - Context lost flag after D1/D2/D3
// - D0, D3 required; D1, D2 optional
// - Wake on link change or wake frame
// - Link changes filtered by a delay
// - Wake frames matched against loaded criteria
// - Wake packet, management, directed traffic
package nps_pkg;
  // Device power states, one-hot
  typedef enum logic [3:0] {
    NPS_D0 = 4'h1,
    NPS_D1 = 4'h2,
    NPS_D2 = 4'h4,
    NPS_D3 = 4'h8
  } nps_state_t;

  // Requested state encoding on the command port
  localparam logic [1:0] NPS_REQ_D0 = 2'h0;
  localparam logic [1:0] NPS_REQ_D1 = 2'h1;
  localparam logic [1:0] NPS_REQ_D2 = 2'h2;
  localparam logic [1:0] NPS_REQ_D3 = 2'h3;

  // Wake frame class bit positions in enable and match vectors
  localparam int NPS_WF_PACKET = 0;
  localparam int NPS_WF_MGMT   = 1;
  localparam int NPS_WF_DIRECT = 2;
  localparam int NPS_WF_N      = 3;

  // Link filter time and derived cycles at 25 MHz
  localparam int NPS_CLK_MHZ      = 25;
  localparam int NPS_LINK_FILT_US = 100;
  localparam int NPS_LINK_FILT_CYC = NPS_LINK_FILT_US * NPS_CLK_MHZ;
endpackage

// ---- hw/nps_link_filter.sv ----
// Debounce filter for the link status input
`timescale 1ns/1ns
module nps_link_filter #(
  parameter int FILT_CYC = nps_pkg::NPS_LINK_FILT_CYC
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic link_raw,
  output logic      link_stable,
  output logic      link_change
);
  localparam int CW = $clog2(FILT_CYC + 1);
  logic [CW-1:0] cnt;

  // Refused at elaboration: a zero length would pass every glitch
  if (FILT_CYC < 1) begin : g_bad_filt
    $error("FILT_CYC must be at least 1");
  end

  // Raw level must differ for FILT_CYC cycles before it is accepted
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt         <= '0;
      link_stable <= 1'b0;
      link_change <= 1'b0;
    end else begin
      link_change <= 1'b0;
      if (link_raw == link_stable) begin
        cnt <= '0; // Glitch too short, start over
      end else if (cnt == CW'(FILT_CYC - 1)) begin
        cnt         <= '0;
        link_stable <= link_raw;
        link_change <= 1'b1;
      end else begin
        cnt <= cnt + CW'(1);
      end
    end
  end

  property p_filter_len;
    @(posedge mclk) disable iff (rst)
      $rose(link_change) |-> $past(link_raw) != $past(link_stable);
  endproperty
  a_filter_len: assert property (p_filter_len)
    else $error("Link change without differing raw level");
endmodule

// ---- hw/nps_core.sv ----
// Power-state, traffic gating and wake logic of a network adapter
`timescale 1ns/1ns
module nps_core #(
  parameter bit HAS_D1   = 1'b1,
  parameter bit HAS_D2   = 1'b1,
  parameter int FILT_CYC = nps_pkg::NPS_LINK_FILT_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ps_req_valid,
  input  wire logic [1:0]  ps_req,
  input  wire logic        wake_en,
  input  wire logic        wake_clr,
  input  wire logic        link_wake_en,
  input  wire logic [2:0]  frame_wake_en,
  input  wire logic        rx_frame_end,
  input  wire logic [2:0]  rx_frame_match,
  input  wire logic        link_raw,
  input  wire logic        tx_req,
  input  wire logic        rx_req,
  input  wire logic        irq_src,
  output logic [3:0]       pwr_state,
  output logic             tx_grant,
  output logic             tx_refused,
  output logic             rx_dma_en,
  output logic             host_irq,
  output logic             context_lost,
  output logic             link_up,
  output logic             wake
);
  nps_pkg::nps_state_t state;
  nps_pkg::nps_state_t next_state;
  logic link_change;
  logic link_stable;
  logic frame_hit;
  logic wake_event;

  // Refused at elaboration: the filter cannot count to zero
  if (FILT_CYC < 1) begin : g_bad_filt
    $error("FILT_CYC must be at least 1");
  end

  nps_link_filter #(.FILT_CYC(FILT_CYC)) u_filt (
    .mclk        (mclk),
    .rst         (rst),
    .link_raw    (link_raw),
    .link_stable (link_stable),
    .link_change (link_change)
  );

  // Unsupported optional states fall to D3, the deepest one
  always_comb begin
    next_state = state;
    if (ps_req_valid) begin
      case (ps_req)
        nps_pkg::NPS_REQ_D0: next_state = nps_pkg::NPS_D0;
        nps_pkg::NPS_REQ_D1: next_state = HAS_D1 ? nps_pkg::NPS_D1
                                                 : nps_pkg::NPS_D3;
        nps_pkg::NPS_REQ_D2: next_state = HAS_D2 ? nps_pkg::NPS_D2
                                                 : nps_pkg::NPS_D3;
        default:             next_state = nps_pkg::NPS_D3;
      endcase
    end
  end

  // State register; the host commands every move
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= nps_pkg::NPS_D0;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pwr_state <= nps_pkg::NPS_D0;
    end else begin
      pwr_state <= next_state;
    end
  end

  // Traffic and interrupts only pass while fully on
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_grant   <= 1'b0;
      tx_refused <= 1'b0;
      rx_dma_en  <= 1'b0;
      host_irq   <= 1'b0;
    end else begin
      tx_grant   <= tx_req && state == nps_pkg::NPS_D0;
      tx_refused <= tx_req && state != nps_pkg::NPS_D0;
      rx_dma_en  <= rx_req && state == nps_pkg::NPS_D0;
      host_irq   <= irq_src && state == nps_pkg::NPS_D0;
    end
  end

  // Sticky: set on leaving D0, cleared once back in D0 and acknowledged
  always_ff @(posedge mclk) begin
    if (rst) begin
      context_lost <= 1'b1;
    end else if (state != nps_pkg::NPS_D0) begin
      context_lost <= 1'b1;
    end else if (wake_clr) begin
      context_lost <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      link_up <= 1'b0;
    end else begin
      link_up <= link_stable;
    end
  end

  // Criteria loaded by software select which frame classes count
  assign frame_hit  = rx_frame_end &&
                      |(rx_frame_match & frame_wake_en);
  assign wake_event = (link_change && link_wake_en) || frame_hit;

  // Wake: new event beats clear; dropped on D0 entry or wake disable
  always_ff @(posedge mclk) begin
    if (rst) begin
      wake <= 1'b0;
    end else if (!wake_en) begin
      wake <= 1'b0;
    end else if (wake_event && state != nps_pkg::NPS_D0) begin
      wake <= 1'b1;
    end else if (wake_clr || state == nps_pkg::NPS_D0) begin
      wake <= 1'b0;
    end
  end

  property p_no_tx_low;
    @(posedge mclk) disable iff (rst)
      state != nps_pkg::NPS_D0 |=> !tx_grant;
  endproperty
  a_no_tx_low: assert property (p_no_tx_low)
    else $error("Transmit granted outside D0");

  property p_no_rx_low;
    @(posedge mclk) disable iff (rst)
      state != nps_pkg::NPS_D0 |=> !rx_dma_en;
  endproperty
  a_no_rx_low: assert property (p_no_rx_low)
    else $error("Receive DMA outside D0");

  property p_no_irq_low;
    @(posedge mclk) disable iff (rst)
      state != nps_pkg::NPS_D0 |=> !host_irq;
  endproperty
  a_no_irq_low: assert property (p_no_irq_low)
    else $error("Interrupt outside D0");

  property p_full_d0;
    @(posedge mclk) disable iff (rst)
      state == nps_pkg::NPS_D0 && tx_req |=> tx_grant && !tx_refused;
  endproperty
  a_full_d0: assert property (p_full_d0)
    else $error("Transmit not granted in D0");

  property p_ctx;
    @(posedge mclk) disable iff (rst)
      state == nps_pkg::NPS_D3 |=> context_lost;
  endproperty
  a_ctx: assert property (p_ctx)
    else $error("Context not flagged lost after D3");

  property p_opt_state;
    @(posedge mclk) disable iff (rst)
      (!HAS_D1 |-> state != nps_pkg::NPS_D1) and
      (!HAS_D2 |-> state != nps_pkg::NPS_D2);
  endproperty
  a_opt_state: assert property (p_opt_state)
    else $error("Unsupported state entered");

  sequence s_low_event;
    wake_en && wake_event && state != nps_pkg::NPS_D0;
  endsequence
  property p_wake_set;
    @(posedge mclk) disable iff (rst)
      s_low_event |=> wake;
  endproperty
  a_wake_set: assert property (p_wake_set)
    else $error("Wake event not raised");

  property p_wake_hold;
    @(posedge mclk) disable iff (rst)
      wake && wake_en && !wake_clr && next_state != nps_pkg::NPS_D0
        && state != nps_pkg::NPS_D0 |=> wake;
  endproperty
  a_wake_hold: assert property (p_wake_hold)
    else $error("Wake dropped early");

  property p_wake_gate;
    @(posedge mclk) disable iff (rst)
      !wake_en |=> !wake;
  endproperty
  a_wake_gate: assert property (p_wake_gate)
    else $error("Wake while disabled");

  property p_frame_mask;
    @(posedge mclk) disable iff (rst)
      wake_en && !wake && rx_frame_end && !link_change &&
      (rx_frame_match & frame_wake_en) == 3'h0 |=> !wake;
  endproperty
  a_frame_mask: assert property (p_frame_mask)
    else $error("Wake from unselected frame class");

  // Every low-state transmit request is answered as refused
  property p_tx_refuse;
    @(posedge mclk) disable iff (rst)
      state != nps_pkg::NPS_D0 && tx_req |=> tx_refused && !tx_grant;
  endproperty
  a_tx_refuse: assert property (p_tx_refuse)
    else $error("Transmit request outside D0 not refused");

  // A clear with no fresh event must drop the wake line
  property p_wake_clear;
    @(posedge mclk) disable iff (rst)
      wake_clr && !wake_event |=> !wake;
  endproperty
  a_wake_clear: assert property (p_wake_clear)
    else $error("Wake not cleared");

  // Once back in D0 the wake line has done its job
  property p_wake_d0;
    @(posedge mclk) disable iff (rst)
      state == nps_pkg::NPS_D0 |=> !wake;
  endproperty
  a_wake_d0: assert property (p_wake_d0)
    else $error("Wake held in D0");
endmodule

// ---- dv/nps_host_model.sv ----
// Host power manager model that issues state commands
`timescale 1ns/1ns
module nps_host_model #(
  parameter logic [1:0] WAKE_ST = nps_pkg::NPS_REQ_D2,
  parameter logic [1:0] PARK_ST = nps_pkg::NPS_REQ_D1
) (
  input  wire logic       ev_v,
  input  wire logic [1:0] ev,
  input  wire logic       wake_en,
  output logic            ps_req_valid,
  output logic [1:0]      ps_req
);
  // Events: 0 resume, 1 sleep, 2 link-down park, 3 shutdown
  assign ps_req_valid = ev_v;
  always_comb begin
    case (ev)
      2'h0: ps_req = nps_pkg::NPS_REQ_D0;
      2'h1: ps_req = wake_en ? WAKE_ST : nps_pkg::NPS_REQ_D3;
      2'h2: ps_req = PARK_ST;
      default: ps_req = nps_pkg::NPS_REQ_D3;
    endcase
  end
endmodule

// ---- dv/nps_core_tb.sv ----
// Self-checking bench for the power-state and wake block
`timescale 1ns/1ns
module nps_core_tb;
  logic       mclk, rst, ev_v, wake_en, wake_clr, lwe, rfe, link_raw;
  logic       tx_req, rx_req, irq_src, ps_v, tx_grant, tx_refused;
  logic       rx_dma_en, host_irq, context_lost, link_up, wake;
  logic [1:0] ev, ps_req;
  logic [2:0] fwe, rfm;
  logic [3:0] pwr_state, es;
  int         num_errors, tests_run;

  nps_host_model host_u (.ev_v(ev_v), .ev(ev), .wake_en(wake_en),
    .ps_req_valid(ps_v), .ps_req(ps_req));
  // D1 left out so a D1 request must land in D3
  nps_core #(.HAS_D1(1'b0), .FILT_CYC(4)) dut_u (.mclk(mclk), .rst(rst),
    .ps_req_valid(ps_v), .ps_req(ps_req), .wake_en(wake_en),
    .wake_clr(wake_clr), .link_wake_en(lwe), .frame_wake_en(fwe),
    .rx_frame_end(rfe), .rx_frame_match(rfm), .link_raw(link_raw),
    .tx_req(tx_req), .rx_req(rx_req), .irq_src(irq_src),
    .pwr_state(pwr_state), .tx_grant(tx_grant), .tx_refused(tx_refused),
    .rx_dma_en(rx_dma_en), .host_irq(host_irq),
    .context_lost(context_lost), .link_up(link_up), .wake(wake));

  task automatic chk(string n, logic [3:0] e, logic [3:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // Expected state after a host event
  function automatic logic [3:0] next_st(logic [1:0] c, logic w);
    case (c)
      2'h0: return 4'h1;
      2'h1: return w ? 4'h4 : 4'h8;
      default: return 4'h8;
    endcase
  endfunction

  // One cycle: random traffic, optional command, then gating checks
  task automatic step(logic v, logic [1:0] c, logic clr, logic fe);
    logic t, r, q;
    logic [3:0] s;
    t = 1'($urandom);
    r = 1'($urandom);
    q = 1'($urandom);
    s = es;
    ev_v = v; ev = c; wake_clr = clr; rfe = fe;
    tx_req = t; rx_req = r; irq_src = q;
    if (v) es = next_st(c, wake_en);
    @(posedge mclk);
    #1;
    chk("pwr_state", es, pwr_state);
    chk("tx_grant", 4'(t && s == 4'h1), 4'(tx_grant));
    chk("tx_refused", 4'(t && s != 4'h1), 4'(tx_refused));
    chk("rx_dma_en", 4'(r && s == 4'h1), 4'(rx_dma_en));
    chk("host_irq", 4'(q && s == 4'h1), 4'(host_irq));
  endtask

  task automatic idle(int n);
    repeat (n) step(0, 0, 0, 0);
  endtask

  task automatic test_done;
    $display("Checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Free-running 25 MHz clock
  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end

  // Watchdog, generous against about 385 cycles of tests
  initial begin
    #(40 * 3000);
    num_errors++;
    test_done;
  end

  // Main sequence
  initial begin
    rst = 1; ev_v = 0; ev = 0; wake_en = 0; wake_clr = 0; lwe = 0;
    fwe = 0; rfe = 0; rfm = 0; link_raw = 0; tx_req = 0; rx_req = 0;
    irq_src = 0; es = 4'h1; num_errors = 0; tests_run = 0;
    void'($urandom(32'h046e956f));
    repeat (2) @(posedge mclk);
    #1 rst = 0;
    chk("context_lost", 1, 4'(context_lost));
    step(0, 0, 1, 0);
    chk("context_lost", 0, 4'(context_lost));
    for (int i = 0; i < 300; i++) begin
      wake_en = 1'($urandom);
      step($urandom_range(3) == 0, 2'($urandom), 0, 0);
    end
    chk("wake", 0, 4'(wake));
    step(1, 3, 0, 0);
    idle(1);
    chk("context_lost", 1, 4'(context_lost));
    // Short link blip must be swallowed, a held one must wake
    wake_en = 1; lwe = 1; link_raw = 1;
    idle(2);
    link_raw = 0;
    idle(12);
    chk("link_up", 0, 4'(link_up));
    chk("wake", 0, 4'(wake));
    link_raw = 1;
    idle(12);
    chk("link_up", 1, 4'(link_up));
    chk("wake", 1, 4'(wake));
    step(0, 0, 1, 0);
    idle(2);
    chk("wake", 0, 4'(wake));
    // Each frame class, first disabled then enabled
    lwe = 0;
    for (int k = 0; k < 3; k++) begin
      fwe = 3'h7 ^ 3'(1 << k);
      rfm = 3'(1 << k);
      step(0, 0, 0, 1);
      idle(3);
      chk("wake", 0, 4'(wake));
      fwe = 3'(1 << k);
      step(0, 0, 0, 1);
      idle(3);
      chk("wake", 1, 4'(wake));
      step(0, 0, 1, 0);
      idle(2);
    end
    // Wake drops with enable, and with the return to D0
    step(0, 0, 0, 1);
    idle(3);
    chk("wake", 1, 4'(wake));
    wake_en = 0;
    idle(3);
    chk("wake", 0, 4'(wake));
    wake_en = 1;
    step(0, 0, 0, 1);
    idle(3);
    step(1, 0, 0, 0);
    idle(2);
    chk("wake", 0, 4'(wake));
    chk("context_lost", 1, 4'(context_lost));
    step(0, 0, 0, 1);
    idle(3);
    chk("wake", 0, 4'(wake));
    test_done;
  end
endmodule
